// ### bench/ldpr_fabric.sv
// partner model: fabric user logic driving one ram port
`timescale 1ns/1ns
module ldpr_fabric (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic we,
  input wire logic ae,
  input wire logic [15:0] addr,
  input wire logic [71:0] wdata,
  input wire logic [7:0] be,
  output logic busy = 1'b0,
  output logic port_clk = 1'b0,
  output logic clk_ena = 1'b0,
  output logic addr_ena = 1'b0,
  output logic wr_sel = 1'b0,
  output logic [15:0] addr_o = 16'h0000,
  output logic [71:0] wdata_o = 72'h0,
  output logic [7:0] be_o = 8'h00
);
  // ****************************************
  // one port clock pulse per request
  // ****************************************
  // clock high 3 and low 3 ref_clk cycles, inputs held for the whole pulse
  // with address enable low the address shown is inverted, so a wrong load shows
  int cnt = 0;
  always @(posedge ref_clk) begin
    if (go && cnt == 0) begin
      cnt <= 1;
      busy <= 1'b1;
      port_clk <= 1'b1;
      clk_ena <= 1'b1;
      addr_ena <= ae;
      wr_sel <= we;
      addr_o <= ae ? addr : ~addr;
      wdata_o <= wdata;
      be_o <= be;
    end else if (cnt == 3) begin
      port_clk <= 1'b0;
      cnt <= 4;
    end else if (cnt == 6) begin
      // released address, data, byte enable and write select lines flip so that no stale value can pass for a held one
      cnt <= 0;
      busy <= 1'b0;
      clk_ena <= 1'b0;
      addr_ena <= 1'b0;
      wr_sel <= ~wr_sel;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
      be_o <= ~be_o;
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### bench/tb_top.sv
// testbench: large dual-port ram against a behavioural model
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic aclr_a = 1'b0;
  logic aclr_b = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic [71:0] rdata_a, rdata_b;
  logic ce = 1'b1;
  logic go [2], we [2], ae [2], busy [2], pclk [2], pena [2], paena [2], pwr [2];
  logic [15:0] adr [2], padr [2];
  logic [71:0] wd [2], pwd [2];
  logic [7:0] be [2], pbe [2];
  // ****************************************
  // behavioural model state
  // ****************************************
  logic [71:0] mem [int];
  logic [71:0] arr_q [2];
  logic [71:0] oq [2];
  logic [71:0] fq [$];
  logic [7:0] ctrl = 8'h0c;
  int mismatches = 0;
  int n_tests = 0;

  initial forever #20 ref_clk = ~ref_clk;

  ldpr_top ldpr_top_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .port_clk_a(pclk[0]), .clk_ena_a(pena[0]), .addr_ena_a(paena[0]), .wr_sel_a(pwr[0]),
    .aclr_a(aclr_a), .addr_a(padr[0]), .wdata_a(pwd[0]), .byte_ena_a(pbe[0]),
    .rdata_a(rdata_a), .port_clk_b(pclk[1]), .clk_ena_b(pena[1]), .addr_ena_b(paena[1]),
    .wr_sel_b(pwr[1]), .aclr_b(aclr_b), .addr_b(padr[1]), .wdata_b(pwd[1]),
    .byte_ena_b(pbe[1]), .rdata_b(rdata_b));

  for (genvar g = 0; g < 2; g++) begin : fab
    ldpr_fabric ldpr_fabric_inst (.ref_clk(ref_clk), .go(go[g]), .we(we[g]), .ae(ae[g]),
      .addr(adr[g]), .wdata(wd[g]), .be(be[g]), .busy(busy[g]), .port_clk(pclk[g]),
      .clk_ena(pena[g]), .addr_ena(paena[g]), .wr_sel(pwr[g]), .addr_o(padr[g]),
      .wdata_o(pwd[g]), .be_o(pbe[g]));
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask

  task automatic set_ctrl(input logic [7:0] v);
    logic [31:0] d;
    cfg_write(8'h00, {24'h0, v});
    ctrl = v;
    fq.delete();
    cfg_read(8'h00, d);
    check("ctrl", {64'h0, v}, {40'h0, d});
  endtask

  // one port transfer, then the port output is compared with the model
  task automatic port_op(input int p, input logic w, input logic [15:0] a,
      input logic [71:0] d, input logic [7:0] e);
    logic [71:0] nw;
    int n;
    @(posedge ref_clk);
    go[p] <= 1'b1;
    we[p] <= w;
    adr[p] <= a;
    wd[p] <= d;
    be[p] <= e;
    ae[p] <= w || e != 8'hff;
    @(posedge ref_clk);
    go[p] <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (busy[p] && n < 20);
    if (busy[p]) mismatches++;
    if (!ctrl[5 + 2 * p]) oq[p] = arr_q[p];
    if (ctrl[1:0] == 2'd3) begin
      if (p == 0 && w) fq.push_back(d);
      else if (p == 1 && !w && fq.size() > 0) arr_q[1] = fq.pop_front();
    end else if (!ctrl[4 + 2 * p] && !(ctrl[1:0] == 2'd2 && p == 1)
        && !(ctrl[1:0] == 2'd1 && (p == 0) != w)) begin
      if (w) begin
        nw = mem.exists(a[12:0]) ? mem[a[12:0]] : 72'h0;
        for (int i = 0; i < 8; i++) if (e[i]) nw[9*i +: 9] = d[9*i +: 9];
        mem[a[12:0]] = nw;
      end else begin
        arr_q[p] = mem[a[12:0]];
      end
    end
    check(p ? "rdata_b" : "rdata_a", ctrl[2 + p] ? oq[p] : arr_q[p], p ? rdata_b : rdata_a);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [71:0] x;
    logic [15:0] a;
    logic [7:0] e;
    void'($urandom(4));
    go = '{2{1'b0}};
    arr_q = '{2{72'h0}};
    oq = '{2{72'h0}};
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("rdata_a", 72'h0, rdata_a);
    check("rdata_b", 72'h0, rdata_b);
    cfg_read(8'h00, d);
    check("ctrl reset", 72'h0c, {40'h0, d});
    cfg_write(8'h08, $urandom());
    cfg_read(8'h08, d);
    check("unmapped", 72'h0, {40'h0, d});
    set_ctrl(8'h00);
    $display("test reset done");
    // partial writes land on the word through the other port, upper address bits ignored
    for (int k = 0; k < 6; k++) begin
      a = 16'($urandom_range(8191));
      x = {8'($urandom()), $urandom(), $urandom()};
      e = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom());
      port_op(0, 1'b1, a, x, 8'hff);
      port_op(1, 1'b1, {3'($urandom()), a[12:0]}, {x[39:0], x[71:40]}, e);
      port_op(0, 1'b0, a, x, 8'hff);
      port_op(1, 1'b0, {3'($urandom()), a[12:0]}, x, 8'h00);
    end
    $display("test byte lanes done");
    set_ctrl(8'h0c);
    port_op(0, 1'b1, 16'h0010, {9{8'h5a}}, 8'hff);
    port_op(0, 1'b1, 16'h0011, {9{8'ha5}}, 8'hff);
    port_op(1, 1'b0, 16'h0010, x, 8'h00);
    port_op(1, 1'b0, 16'h0011, x, 8'h00);
    port_op(1, 1'b0, 16'h0011, x, 8'h00);
    @(posedge ref_clk);
    aclr_b <= 1'b1;
    #1;
    check("aclr rdata_b", 72'h0, rdata_b);
    @(posedge ref_clk);
    aclr_b <= 1'b0;
    oq[1] = 72'h0;
    port_op(1, 1'b0, 16'h0010, x, 8'h00);
    $display("test output register done");
    set_ctrl(8'h01);
    port_op(0, 1'b1, 16'h0020, {9{8'h3c}}, 8'hff);
    port_op(1, 1'b0, 16'h0020, x, 8'h00);
    port_op(1, 1'b1, 16'h0021, {9{8'hc3}}, 8'hff);
    port_op(0, 1'b0, 16'h0020, x, 8'h00);
    set_ctrl(8'h02);
    port_op(0, 1'b1, 16'h0021, {9{8'h66}}, 8'hff);
    port_op(0, 1'b0, 16'h0021, x, 8'h00);
    port_op(1, 1'b0, 16'h0020, x, 8'h00);
    set_ctrl(8'h00);
    port_op(0, 1'b0, 16'h0020, x, 8'h00);
    port_op(0, 1'b1, 16'h0030, {9{8'h99}}, 8'hff);
    set_ctrl(8'h34);
    port_op(0, 1'b1, 16'h0030, {9{8'h11}}, 8'hff);
    set_ctrl(8'h00);
    port_op(0, 1'b0, 16'h0030, x, 8'h00);
    @(posedge ref_clk);
    ce <= 1'b0;
    cfg_write(8'h00, 32'h0000_0003);
    ce <= 1'b1;
    cfg_read(8'h00, d);
    check("ce freeze", {64'h0, ctrl}, {40'h0, d});
    $display("test modes done");
    set_ctrl(8'h03);
    for (int k = 0; k < 3; k++) begin
      port_op(0, 1'b1, 16'($urandom()), {8'($urandom()), $urandom(), $urandom()}, 8'hff);
    end
    cfg_read(8'h04, d);
    check("fifo count", 72'h3, {58'h0, d[13:0]});
    for (int k = 0; k < 4; k++) begin
      port_op(1, 1'b0, 16'h0000, x, 8'h00);
    end
    cfg_read(8'h04, d);
    check("fifo flags", {54'h0, 4'h9, 14'h0}, {54'h0, d[19:16], d[13:0]});
    cfg_write(8'h04, 32'h0008_0000);
    cfg_read(8'h04, d);
    check("fifo underflow clear", 72'h0, {71'h0, d[19]});
    $display("test fifo done");
    final_report();
  end

  // the whole run needs about 450 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule

// ### hdl/ldpr_mem.sv
// module: storage array with two ports and registered read data
`timescale 1ns/1ns
module ldpr_mem #(
  parameter int DEPTH = ldpr_pkg::DEPTH,
  parameter int AW = ldpr_pkg::WORD_AW,
  parameter int BW = ldpr_pkg::BE_W,
  parameter int LW = ldpr_pkg::LANE_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic en_a,
  input wire logic we_a,
  input wire logic [BW-1:0] be_a,
  input wire logic [AW-1:0] addr_a,
  input wire logic [BW*LW-1:0] wdata_a,
  output logic [BW*LW-1:0] q_a,
  input wire logic en_b,
  input wire logic we_b,
  input wire logic [BW-1:0] be_b,
  input wire logic [AW-1:0] addr_b,
  input wire logic [BW*LW-1:0] wdata_b,
  output logic [BW*LW-1:0] q_b
);
  logic [BW*LW-1:0] ram [DEPTH];

  // no image and no reset for the array: it powers up undefined
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      for (int i = 0; i < BW; i++) begin
        if (en_a && we_a && be_a[i]) begin
          ram[addr_a][i*LW +: LW] <= wdata_a[i*LW +: LW];
        end
        if (en_b && we_b && be_b[i]) begin
          ram[addr_b][i*LW +: LW] <= wdata_b[i*LW +: LW];
        end
      end
    end
  end

  // a same-address write from the other port is not seen: the read returns the old word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_a <= '0;
      q_b <= '0;
    end else if (ce) begin
      if (en_a && !we_a) begin
        q_a <= ram[addr_a];
      end
      if (en_b && !we_b) begin
        q_b <= ram[addr_b];
      end
    end
  end
endmodule

// ### hdl/ldpr_pkg.sv
// package: constants and types shared by the large dual-port ram
// How it works
// - array holds 589,824 bits, parity included, as 8192 words of 72 bits.
// - modes are true dual-port, simple dual-port, single-port or fifo; no rom.
// - contents are never preloaded from any image.
// - array contents are undefined until first written.
// - address, data, byte enables and write select are captured in a register on a port clock edge.
// - each port output register is either used or bypassed.
// - input and output register groups may each take either port clock.
// - ports a and b have independent control inputs.
// - port takes address, address enable, clock, clock enable, write select, clear.
// - each port has 72 data in, 8 byte enables, 72 data out.
// - port clear empties its output register at once, no clock needed.
// - port clear empties input registers at once; array sees it next edge.
package ldpr_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int MEM_BITS = 589824;
  localparam int DATA_W = 72;
  localparam int BE_W = 8;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 16;
  localparam int WORD_AW = 13;
  localparam int DEPTH = 8192;
  localparam int CFG_AW = 8;
  localparam int CFG_DW = 32;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OREG_A = 2;
  localparam int CTRL_OREG_B = 3;
  localparam int CTRL_ISEL_A = 4;
  localparam int CTRL_OSEL_A = 5;
  localparam int CTRL_ISEL_B = 6;
  localparam int CTRL_OSEL_B = 7;
  localparam logic [7:0] CTRL_RST = 8'h0c;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_EMPTY = 16;
  localparam int STAT_FULL = 17;
  localparam int STAT_OVF = 18;
  localparam int STAT_UNF = 19;
  typedef enum logic [1:0] {LDPR_TDP, LDPR_SDP, LDPR_SP, LDPR_FIFO} ldpr_mode_t;
endpackage

// ### hdl/ldpr_port.sv
// module: input and output registers of one ram port
`timescale 1ns/1ns
module ldpr_port #(
  parameter int AW = ldpr_pkg::ADDR_W,
  parameter int DW = ldpr_pkg::DATA_W,
  parameter int BW = ldpr_pkg::BE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_tick,
  input wire logic out_tick,
  input wire logic clk_ena,
  input wire logic addr_ena,
  input wire logic wr_sel,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [BW-1:0] byte_ena,
  input wire logic [DW-1:0] mem_q,
  input wire logic use_oreg,
  output logic req_valid,
  output logic req_we,
  output logic [AW-1:0] req_addr,
  output logic [DW-1:0] req_wdata,
  output logic [BW-1:0] req_be,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic valid;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [BW-1:0] be;
    logic [DW-1:0] oq;
  } ldpr_port_t;

  ldpr_port_t st;
  ldpr_port_t next_st;

  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    if (in_tick && clk_ena) begin
      next_st.valid = 1'b1;
      next_st.we = wr_sel;
      next_st.wdata = wdata;
      next_st.be = byte_ena;
      if (addr_ena) begin
        next_st.addr = addr;
      end
    end
    if (out_tick && clk_ena) begin
      next_st.oq = mem_q;
    end
  end

  // rst_n carries the port clear, so both register groups empty at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign req_valid = st.valid;
  assign req_we = st.we;
  assign req_addr = st.addr;
  assign req_wdata = st.wdata;
  assign req_be = st.be;
  assign rdata = use_oreg ? st.oq : mem_q;
endmodule

// ### hdl/ldpr_top.sv
// module: large dual-port ram with modes, fifo pointers and config port
`timescale 1ns/1ns
module ldpr_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  input wire logic port_clk_a,
  input wire logic clk_ena_a,
  input wire logic addr_ena_a,
  input wire logic wr_sel_a,
  input wire logic aclr_a,
  input wire logic [15:0] addr_a,
  input wire logic [71:0] wdata_a,
  input wire logic [7:0] byte_ena_a,
  output logic [71:0] rdata_a,
  input wire logic port_clk_b,
  input wire logic clk_ena_b,
  input wire logic addr_ena_b,
  input wire logic wr_sel_b,
  input wire logic aclr_b,
  input wire logic [15:0] addr_b,
  input wire logic [71:0] wdata_b,
  input wire logic [7:0] byte_ena_b,
  output logic [71:0] rdata_b
);
  // ****************************************
  // state
  // ****************************************
  localparam int AW = ldpr_pkg::WORD_AW;
  localparam int PW = ldpr_pkg::WORD_AW + 1;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    ldpr_pkg::ldpr_mode_t mode;
    logic [1:0] oreg;
    logic [1:0] isel;
    logic [1:0] osel;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic ovf;
    logic unf;
    logic [31:0] rd;
  } ldpr_top_t;

  localparam ldpr_top_t RST_ST = '{
    mode: ldpr_pkg::ldpr_mode_t'(ldpr_pkg::CTRL_RST[1:0]),
    oreg: {ldpr_pkg::CTRL_RST[3], ldpr_pkg::CTRL_RST[2]},
    isel: {ldpr_pkg::CTRL_RST[6], ldpr_pkg::CTRL_RST[4]},
    osel: {ldpr_pkg::CTRL_RST[7], ldpr_pkg::CTRL_RST[5]},
    default: '0
  };

  ldpr_top_t st;
  ldpr_top_t next_st;

  logic [1:0] tick;
  logic in_tick_a;
  logic in_tick_b;
  logic out_tick_a;
  logic out_tick_b;
  logic prst_n_a;
  logic prst_n_b;
  logic req_valid_a;
  logic req_we_a;
  logic [15:0] req_addr_a;
  logic [71:0] req_wdata_a;
  logic [7:0] req_be_a;
  logic req_valid_b;
  logic req_we_b;
  logic [15:0] req_addr_b;
  logic [71:0] req_wdata_b;
  logic [7:0] req_be_b;
  logic [71:0] mem_q_a;
  logic [71:0] mem_q_b;
  logic mem_en_a;
  logic mem_we_a;
  logic [AW-1:0] mem_addr_a;
  logic mem_en_b;
  logic mem_we_b;
  logic [AW-1:0] mem_addr_b;
  logic [PW-1:0] cnt;
  logic empty;
  logic full;
  logic push;
  logic pop;
  logic push_bad;
  logic pop_bad;

  // ****************************************
  // port clocks
  // ****************************************
  // a port clock is seen as a rising edge after two flops, so each half
  // of its period must last at least two ref_clk cycles
  assign tick = st.s2 & ~st.s3;
  assign in_tick_a = st.isel[0] ? tick[1] : tick[0];
  assign in_tick_b = st.isel[1] ? tick[0] : tick[1];
  assign out_tick_a = st.osel[0] ? tick[1] : tick[0];
  assign out_tick_b = st.osel[1] ? tick[0] : tick[1];
  assign prst_n_a = arst_n & ~aclr_a;
  assign prst_n_b = arst_n & ~aclr_b;

  // ****************************************
  // ports
  // ****************************************
  ldpr_port u_port_a (
    .ref_clk(ref_clk),
    .rst_n(prst_n_a),
    .ce(ce),
    .in_tick(in_tick_a),
    .out_tick(out_tick_a),
    .clk_ena(clk_ena_a),
    .addr_ena(addr_ena_a),
    .wr_sel(wr_sel_a),
    .addr(addr_a),
    .wdata(wdata_a),
    .byte_ena(byte_ena_a),
    .mem_q(mem_q_a),
    .use_oreg(st.oreg[0]),
    .req_valid(req_valid_a),
    .req_we(req_we_a),
    .req_addr(req_addr_a),
    .req_wdata(req_wdata_a),
    .req_be(req_be_a),
    .rdata(rdata_a)
  );

  ldpr_port u_port_b (
    .ref_clk(ref_clk),
    .rst_n(prst_n_b),
    .ce(ce),
    .in_tick(in_tick_b),
    .out_tick(out_tick_b),
    .clk_ena(clk_ena_b),
    .addr_ena(addr_ena_b),
    .wr_sel(wr_sel_b),
    .addr(addr_b),
    .wdata(wdata_b),
    .byte_ena(byte_ena_b),
    .mem_q(mem_q_b),
    .use_oreg(st.oreg[1]),
    .req_valid(req_valid_b),
    .req_we(req_we_b),
    .req_addr(req_addr_b),
    .req_wdata(req_wdata_b),
    .req_be(req_be_b),
    .rdata(rdata_b)
  );

  // ****************************************
  // mode steering
  // ****************************************
  assign cnt = st.wptr - st.rptr;
  assign empty = (cnt == '0);
  assign full = (cnt == PW'(ldpr_pkg::DEPTH));

  always_comb begin
    mem_en_a = req_valid_a;
    mem_we_a = req_we_a;
    mem_addr_a = req_addr_a[AW-1:0];
    mem_en_b = req_valid_b;
    mem_we_b = req_we_b;
    mem_addr_b = req_addr_b[AW-1:0];
    push = 1'b0;
    pop = 1'b0;
    push_bad = 1'b0;
    pop_bad = 1'b0;
    case (st.mode)
      ldpr_pkg::LDPR_TDP: begin
      end
      ldpr_pkg::LDPR_SDP: begin
        mem_en_a = req_valid_a & req_we_a;
        mem_we_a = 1'b1;
        mem_en_b = req_valid_b & ~req_we_b;
        mem_we_b = 1'b0;
      end
      ldpr_pkg::LDPR_SP: begin
        mem_en_b = 1'b0;
        mem_we_b = 1'b0;
      end
      ldpr_pkg::LDPR_FIFO: begin
        // a push into a full fifo or a pop from an empty one is dropped
        push = req_valid_a & req_we_a & ~full;
        pop = req_valid_b & ~req_we_b & ~empty;
        push_bad = req_valid_a & req_we_a & full;
        pop_bad = req_valid_b & ~req_we_b & empty;
        mem_en_a = push;
        mem_we_a = 1'b1;
        mem_addr_a = st.wptr[AW-1:0];
        mem_en_b = pop;
        mem_we_b = 1'b0;
        mem_addr_b = st.rptr[AW-1:0];
      end
      default: begin
        mem_en_a = 1'b0;
        mem_en_b = 1'b0;
      end
    endcase
  end

  // ****************************************
  // array
  // ****************************************
  ldpr_mem u_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .en_a(mem_en_a),
    .we_a(mem_we_a),
    .be_a(req_be_a),
    .addr_a(mem_addr_a),
    .wdata_a(req_wdata_a),
    .q_a(mem_q_a),
    .en_b(mem_en_b),
    .we_b(mem_we_b),
    .be_b(req_be_b),
    .addr_b(mem_addr_b),
    .wdata_b(req_wdata_b),
    .q_b(mem_q_b)
  );

  // ****************************************
  // next state and config port
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.s1 = {port_clk_b, port_clk_a};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rd = '0;
    if (push) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    if (cfg_wr && cfg_addr == ldpr_pkg::CTRL_OFF) begin
      next_st.mode = ldpr_pkg::ldpr_mode_t'(cfg_wdata[ldpr_pkg::CTRL_MODE_LSB +: 2]);
      next_st.oreg[0] = cfg_wdata[ldpr_pkg::CTRL_OREG_A];
      next_st.oreg[1] = cfg_wdata[ldpr_pkg::CTRL_OREG_B];
      next_st.isel[0] = cfg_wdata[ldpr_pkg::CTRL_ISEL_A];
      next_st.osel[0] = cfg_wdata[ldpr_pkg::CTRL_OSEL_A];
      next_st.isel[1] = cfg_wdata[ldpr_pkg::CTRL_ISEL_B];
      next_st.osel[1] = cfg_wdata[ldpr_pkg::CTRL_OSEL_B];
      // a mode change would leave stale pointers, so they restart
      next_st.wptr = '0;
      next_st.rptr = '0;
    end
    if (cfg_wr && cfg_addr == ldpr_pkg::STAT_OFF) begin
      if (cfg_wdata[ldpr_pkg::STAT_OVF]) begin
        next_st.ovf = 1'b0;
      end
      if (cfg_wdata[ldpr_pkg::STAT_UNF]) begin
        next_st.unf = 1'b0;
      end
    end
    // set after clear: an event in the clearing cycle is kept
    if (push_bad) begin
      next_st.ovf = 1'b1;
    end
    if (pop_bad) begin
      next_st.unf = 1'b1;
    end
    if (cfg_rd && cfg_addr == ldpr_pkg::CTRL_OFF) begin
      next_st.rd[ldpr_pkg::CTRL_MODE_LSB +: 2] = st.mode;
      next_st.rd[ldpr_pkg::CTRL_OREG_A] = st.oreg[0];
      next_st.rd[ldpr_pkg::CTRL_OREG_B] = st.oreg[1];
      next_st.rd[ldpr_pkg::CTRL_ISEL_A] = st.isel[0];
      next_st.rd[ldpr_pkg::CTRL_OSEL_A] = st.osel[0];
      next_st.rd[ldpr_pkg::CTRL_ISEL_B] = st.isel[1];
      next_st.rd[ldpr_pkg::CTRL_OSEL_B] = st.osel[1];
    end
    if (cfg_rd && cfg_addr == ldpr_pkg::STAT_OFF) begin
      next_st.rd[ldpr_pkg::STAT_CNT_LSB +: PW] = cnt;
      next_st.rd[ldpr_pkg::STAT_EMPTY] = empty;
      next_st.rd[ldpr_pkg::STAT_FULL] = full;
      next_st.rd[ldpr_pkg::STAT_OVF] = st.ovf;
      next_st.rd[ldpr_pkg::STAT_UNF] = st.unf;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST_ST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rd;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic rd_seen_b;
  assign rd_seen_b = mem_en_b & ~mem_we_b & ce;

  sequence fifo_push_full_s;
    st.mode == ldpr_pkg::LDPR_FIFO && full && req_valid_a && req_we_a && ce;
  endsequence

  sequence fifo_pop_empty_s;
    st.mode == ldpr_pkg::LDPR_FIFO && empty && req_valid_b && !req_we_b && ce;
  endsequence

  sequence capture_a_s;
    in_tick_a && clk_ena_a && !aclr_a && ce;
  endsequence

  sequence oreg_quiet_a_s;
    st.oreg[0] && ce && !cfg_wr && !(out_tick_a && clk_ena_a) ##1 !aclr_a;
  endsequence

  cap_size_a: assert property (
    ldpr_pkg::DEPTH * ldpr_pkg::DATA_W == ldpr_pkg::MEM_BITS)
    else $error("array size differs from the capacity");

  b_no_write_a: assert property (
    st.mode != ldpr_pkg::LDPR_TDP |-> !(mem_en_b && mem_we_b))
    else $error("port b wrote outside true dual-port mode");

  sp_b_idle_a: assert property (
    st.mode == ldpr_pkg::LDPR_SP |-> !mem_en_b)
    else $error("port b active in single-port mode");

  fifo_ovf_a: assert property (
    fifo_push_full_s |-> !mem_en_a ##1 st.ovf)
    else $error("push into full fifo not refused");

  fifo_unf_a: assert property (
    fifo_pop_empty_s |-> !mem_en_b ##1 st.unf)
    else $error("pop from empty fifo not refused");

  in_capture_a: assert property (
    capture_a_s |=> req_valid_a || aclr_a)
    else $error("port a input not captured on its clock");

  addr_hold_a: assert property (
    capture_a_s ##0 !addr_ena_a |=> $stable(req_addr_a) || aclr_a)
    else $error("address loaded with address enable low");

  clk_select_a: assert property (
    st.isel[0] && tick[0] && !tick[1] && ce && !cfg_wr |=> !req_valid_a)
    else $error("port a captured on the unselected clock");

  oreg_clear_a: assert property (
    aclr_b && st.oreg[1] |-> rdata_b == '0)
    else $error("port b output register not cleared");

  in_clear_a: assert property (
    aclr_b |-> !req_valid_b)
    else $error("port b input register not cleared");

  oreg_hold_a: assert property (
    oreg_quiet_a_s |-> $stable(rdata_a))
    else $error("registered output changed without its clock");

  bypass_rd_a: assert property (
    !st.oreg[1] && !cfg_wr && !rd_seen_b && ce |=> $stable(rdata_b) || aclr_b)
    else $error("bypassed output changed without an array read");

  freeze_a: assert property (
    !ce |=> $stable(st))
    else $error("state moved with clock enable low");
endmodule
